// >>> logic/tws_brg.v
// Bit rate generator: quarter-period tick for the bus clock
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_brg #(
   parameter CW = 16
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire run,
   input wire [7:0] bitRate,
   input wire [1:0] prescSel,
   output reg tick_q
);
   reg [CW-1:0] cnt_q;
   wire [CW-1:0] scaled;
   wire [CW-1:0] limit;

   // Prescaler 1, 4, 16 or 64 as a left shift by twice the select
   assign scaled = {{(CW-8){1'b0}}, bitRate} << {prescSel, 1'b0};
   assign limit = (scaled >> 1) + `TWS_QTR_BASE;

   always @(posedge clk) begin
      if (rst) begin
         cnt_q <= {CW{1'b0}};
         tick_q <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            cnt_q <= {CW{1'b0}};
            tick_q <= 1'b0;
         end else if (cnt_q >= limit - 1'b1) begin
            cnt_q <= {CW{1'b0}};
            tick_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
         end
      end
   end
endmodule

// >>> logic/tws_consts.vh
// Constants of the two-wire serial controller register block
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH
// Register offsets
`define TWS_OFF_BITRATE 8'hb8
`define TWS_OFF_STATUS 8'hb9
`define TWS_OFF_OWNADDR 8'hba
`define TWS_OFF_DATA 8'hbb
`define TWS_OFF_CTRL 8'hbc
`define TWS_OFF_MASK 8'hbd
// Reset values
`define TWS_RST_BITRATE 8'h00
`define TWS_RST_PRESC 2'h0
`define TWS_RST_OWNADDR 8'hfe
`define TWS_RST_DATA 8'hff
`define TWS_RST_CTRL 8'h00
`define TWS_RST_MASK 8'h00
// Control register bit positions
`define TWS_CB_INT 7
`define TWS_CB_ACK 6
`define TWS_CB_STA 5
`define TWS_CB_STO 4
`define TWS_CB_WC 3
`define TWS_CB_EN 2
`define TWS_CB_IE 0
// Own address register fields
`define TWS_GCE_BIT 0
`define TWS_GC_ADDR 7'h00
// Bit rate generator: quarter bus period is base + (bitrate * prescale) / 2
`define TWS_QTR_BASE 16'h0004
// Status codes
`define TWS_ST_START 8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_MT_SLA_ACK 8'h18
`define TWS_ST_MT_SLA_NACK 8'h20
`define TWS_ST_MT_DAT_ACK 8'h28
`define TWS_ST_MT_DAT_NACK 8'h30
`define TWS_ST_ARB_LOST 8'h38
`define TWS_ST_MR_SLA_ACK 8'h40
`define TWS_ST_MR_SLA_NACK 8'h48
`define TWS_ST_MR_DAT_ACK 8'h50
`define TWS_ST_MR_DAT_NACK 8'h58
`define TWS_ST_SR_SLA_ACK 8'h60
`define TWS_ST_SR_GC_ACK 8'h70
`define TWS_ST_SR_DAT_ACK 8'h80
`define TWS_ST_SR_DAT_NACK 8'h88
`define TWS_ST_SR_GC_DAT_ACK 8'h90
`define TWS_ST_SR_GC_DAT_NACK 8'h98
`define TWS_ST_SR_STOP 8'ha0
`define TWS_ST_ST_SLA_ACK 8'ha8
`define TWS_ST_ST_DAT_ACK 8'hb8
`define TWS_ST_ST_DAT_NACK 8'hc0
`define TWS_ST_NONE 8'hf8
`define TWS_ST_LOST_OFS 8'h08
`endif

// >>> logic/tws_ctrl.v
// Two-wire serial controller with its register set and bus engine
//
// Functional notes
// - Prescaler select is read/write; 00,01,10,11 scale bit rate by 1,4,16,64.
// - Slave address compare uses upper seven bits of own address register.
// - Own address bit zero enables recognition of general call address 0x00.
// - An own or enabled general call address match raises the interrupt flag.
// - Data register holds byte to send or received; writable only while flag set.
// - Data register stable while flag set; bus bits shift in as bits shift out.
// - Acknowledge handled by hardware; lost arbitration loses no data.
// - Flag bit 7 sets when job done; bus clock held low while set, except after a slave STOP (0xA0) or lost arbitration (0x38).
// - Flag cleared only by writing one; clearing starts the next operation.
// - With ack enable set, acknowledge own address, enabled general call, data.
// - Ack enable cleared: device ignores bus; set again resumes address recognition.
// - Start request waits for free bus or a STOP, then issues START.
// - Master stop request issues STOP; hardware clears the request afterwards.
// - Slave stop request sends nothing; return to unaddressed and release lines.
// - Data write with flag low sets collision; with flag high clears it.
// - Enable gives pins to controller; clearing it aborts everything at once.
// - Interrupt output follows the flag while enable and global enable set.
// - Each set mask bit excludes that address bit from the comparison.
// - Bit rate register sets the divider of the master bus clock.
// - Status code bits read 0xF8 while the flag is low; bits 1:0 read the prescaler select.
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_ctrl (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [7:0] regAddr,
   input wire regWr,
   input wire [7:0] regWrData,
   output reg [7:0] regRdData_q,
   input wire cpuIntEn,
   output reg irq_q,
   input wire sclIn,
   output reg sclOut_q,
   output reg sclOe_q,
   input wire sdaIn,
   output reg sdaOut_q,
   output reg sdaOe_q
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_BIT = 3'h2;
   localparam [2:0] ST_HOLD = 3'h3;
   localparam [2:0] ST_STOP = 3'h4;
   localparam [7:0] CTRL_RST = `TWS_RST_CTRL;
   localparam [7:0] STAT_NONE = `TWS_ST_NONE;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] bitRate_q;
   reg [1:0] presc_q;
   reg [7:0] ownAddr_q;
   reg [7:0] data_q;
   reg [7:0] mask_q;
   reg [7:0] status_q;
   reg intFlag_q, ackEn_q, startReq_q, stopReq_q, wrCol_q, ifaceEn_q, intEn_q;
   reg [2:0] state_q;
   reg [1:0] phase_q;
   reg [3:0] bitCnt_q;
   reg master_q, slvAddr_q, addrPhase_q, rx_q, lost_q, gc_q, ackRx_q, busBusy_q;
   reg sclRaw_q, sdaRaw_q, sclF_q, sdaF_q, sclFPrev_q, sdaFPrev_q;
   wire tick;
   wire sclRise, sclFall, startDet, stopDet, addrHit, gcHit, brgRun;

   function matchAddr;
      input [6:0] rxAddr;
      input [6:0] own;
      input [6:0] mask;
      begin
         matchAddr = &((~(rxAddr ^ own)) | mask);
      end
   endfunction

   // ---------------------------------------------------------------
   // Bus conditions and address compare
   // ---------------------------------------------------------------
   assign sclRise = sclF_q & ~sclFPrev_q;
   assign sclFall = ~sclF_q & sclFPrev_q;
   assign startDet = sclF_q & sclFPrev_q & ~sdaF_q & sdaFPrev_q;
   assign stopDet = sclF_q & sclFPrev_q & sdaF_q & ~sdaFPrev_q;
   assign addrHit = matchAddr(data_q[7:1], ownAddr_q[7:1], mask_q[7:1]);
   assign gcHit = ownAddr_q[`TWS_GCE_BIT] & (data_q[7:1] == `TWS_GC_ADDR);
   assign brgRun = (state_q == ST_START) | (state_q == ST_STOP) | ((state_q == ST_BIT) & master_q);

   tws_brg #(
      .CW(16)
   ) u_brg (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .run(brgRun),
      .bitRate(bitRate_q),
      .prescSel(presc_q),
      .tick_q(tick)
   );

   always @(posedge clk) begin
      if (rst) begin
         bitRate_q <= `TWS_RST_BITRATE;
         presc_q <= `TWS_RST_PRESC;
         ownAddr_q <= `TWS_RST_OWNADDR;
         data_q <= `TWS_RST_DATA;
         mask_q <= `TWS_RST_MASK;
         status_q <= `TWS_ST_NONE;
         intFlag_q <= CTRL_RST[`TWS_CB_INT];
         ackEn_q <= CTRL_RST[`TWS_CB_ACK];
         startReq_q <= CTRL_RST[`TWS_CB_STA];
         stopReq_q <= CTRL_RST[`TWS_CB_STO];
         wrCol_q <= CTRL_RST[`TWS_CB_WC];
         ifaceEn_q <= CTRL_RST[`TWS_CB_EN];
         intEn_q <= CTRL_RST[`TWS_CB_IE];
         state_q <= ST_IDLE;
         phase_q <= 2'h0;
         bitCnt_q <= 4'h0;
         master_q <= 1'b0;
         slvAddr_q <= 1'b0;
         addrPhase_q <= 1'b0;
         rx_q <= 1'b0;
         lost_q <= 1'b0;
         gc_q <= 1'b0;
         ackRx_q <= 1'b0;
         busBusy_q <= 1'b0;
         sclRaw_q <= 1'b1;
         sdaRaw_q <= 1'b1;
         sclF_q <= 1'b1;
         sdaF_q <= 1'b1;
         sclFPrev_q <= 1'b1;
         sdaFPrev_q <= 1'b1;
         regRdData_q <= 8'h00;
         irq_q <= 1'b0;
         sclOut_q <= 1'b0;
         sdaOut_q <= 1'b0;
         sclOe_q <= 1'b0;
         sdaOe_q <= 1'b0;
      end else if (ce) begin
         // ---------------------------------------------------------------
         // Input spike filter and bus busy tracking
         // ---------------------------------------------------------------
         sclRaw_q <= sclIn;
         sdaRaw_q <= sdaIn;
         if (sclIn == sclRaw_q) begin
            sclF_q <= sclIn;
         end
         if (sdaIn == sdaRaw_q) begin
            sdaF_q <= sdaIn;
         end
         sclFPrev_q <= sclF_q;
         sdaFPrev_q <= sdaF_q;
         if (startDet) begin
            busBusy_q <= 1'b1;
         end else if (stopDet) begin
            busBusy_q <= 1'b0;
         end

         // ---------------------------------------------------------------
         // Register writes and reads
         // ---------------------------------------------------------------
         if (regWr) begin
            if (regAddr == `TWS_OFF_BITRATE) begin
               bitRate_q <= regWrData;
            end else if (regAddr == `TWS_OFF_STATUS) begin
               presc_q <= regWrData[1:0];
            end else if (regAddr == `TWS_OFF_OWNADDR) begin
               ownAddr_q <= regWrData;
            end else if (regAddr == `TWS_OFF_DATA) begin
               if (intFlag_q) begin
                  data_q <= regWrData;
                  wrCol_q <= 1'b0;
               end else begin
                  wrCol_q <= 1'b1;
               end
            end else if (regAddr == `TWS_OFF_CTRL) begin
               if (regWrData[`TWS_CB_INT]) begin
                  intFlag_q <= 1'b0;
               end
               ackEn_q <= regWrData[`TWS_CB_ACK];
               startReq_q <= regWrData[`TWS_CB_STA];
               stopReq_q <= regWrData[`TWS_CB_STO];
               ifaceEn_q <= regWrData[`TWS_CB_EN];
               intEn_q <= regWrData[`TWS_CB_IE];
            end else if (regAddr == `TWS_OFF_MASK) begin
               mask_q <= {regWrData[7:1], 1'b0};
            end
         end
         if (regAddr == `TWS_OFF_BITRATE) begin
            regRdData_q <= bitRate_q;
         end else if (regAddr == `TWS_OFF_STATUS) begin
            regRdData_q <= {(intFlag_q ? status_q[7:3] : STAT_NONE[7:3]), 1'b0, presc_q};
         end else if (regAddr == `TWS_OFF_OWNADDR) begin
            regRdData_q <= ownAddr_q;
         end else if (regAddr == `TWS_OFF_DATA) begin
            regRdData_q <= data_q;
         end else if (regAddr == `TWS_OFF_CTRL) begin
            regRdData_q <= {intFlag_q, ackEn_q, startReq_q, stopReq_q, wrCol_q, ifaceEn_q, 1'b0, intEn_q};
         end else if (regAddr == `TWS_OFF_MASK) begin
            regRdData_q <= mask_q;
         end else begin
            regRdData_q <= 8'h00;
         end
         irq_q <= intEn_q & cpuIntEn & intFlag_q;

         // ---------------------------------------------------------------
         // Bus engine
         // ---------------------------------------------------------------
         case (state_q)
            ST_IDLE: begin
               sclOe_q <= 1'b0;
               sdaOe_q <= 1'b0;
               bitCnt_q <= 4'h0;
               if (startReq_q & ~intFlag_q & ~busBusy_q) begin
                  state_q <= ST_START;
                  phase_q <= 2'h1;
               end else if (startDet & ackEn_q) begin
                  state_q <= ST_BIT;
                  phase_q <= 2'h1;
                  addrPhase_q <= 1'b1;
                  rx_q <= 1'b1;
                  lost_q <= 1'b0;
               end
            end
            ST_START: begin
               if (phase_q == 2'h0) begin
                  sdaOe_q <= 1'b0;
                  if (tick) begin
                     sclOe_q <= 1'b0;
                     phase_q <= 2'h1;
                  end
               end else if (phase_q == 2'h1) begin
                  if (tick & sclF_q & sdaF_q) begin
                     sdaOe_q <= 1'b1;
                     phase_q <= 2'h2;
                  end
               end else if (tick) begin
                  sclOe_q <= 1'b1;
                  intFlag_q <= 1'b1;
                  status_q <= master_q ? `TWS_ST_RSTART : `TWS_ST_START;
                  master_q <= 1'b1;
                  addrPhase_q <= 1'b1;
                  rx_q <= 1'b0;
                  lost_q <= 1'b0;
                  bitCnt_q <= 4'h0;
                  state_q <= ST_HOLD;
               end
            end
            ST_BIT: begin
               if (master_q) begin
                  if (phase_q == 2'h0) begin
                     if (tick) begin
                        sdaOe_q <= bitCnt_q[3] ? (rx_q & ackEn_q) : (~rx_q & ~data_q[7]);
                        phase_q <= 2'h1;
                     end
                  end else if (phase_q == 2'h1) begin
                     if (tick) begin
                        sclOe_q <= 1'b0;
                        phase_q <= 2'h2;
                     end
                  end else if (phase_q == 2'h2) begin
                     if (tick & sclF_q) begin
                        phase_q <= 2'h3;
                        if (bitCnt_q[3]) begin
                           ackRx_q <= ~sdaF_q;
                        end else begin
                           data_q <= {data_q[6:0], sdaF_q};
                           if (~rx_q & data_q[7] & ~sdaF_q) begin
                              master_q <= 1'b0;
                              lost_q <= 1'b1;
                              sdaOe_q <= 1'b0;
                           end
                        end
                     end
                  end else if (tick) begin
                     sclOe_q <= 1'b1;
                     phase_q <= 2'h0;
                     if (bitCnt_q[3]) begin
                        bitCnt_q <= 4'h0;
                        intFlag_q <= 1'b1;
                        state_q <= ST_HOLD;
                        addrPhase_q <= 1'b0;
                        if (addrPhase_q) begin
                           rx_q <= data_q[0];
                           if (data_q[0]) begin
                              status_q <= ackRx_q ? `TWS_ST_MR_SLA_ACK : `TWS_ST_MR_SLA_NACK;
                           end else begin
                              status_q <= ackRx_q ? `TWS_ST_MT_SLA_ACK : `TWS_ST_MT_SLA_NACK;
                           end
                        end else if (rx_q) begin
                           status_q <= ackRx_q ? `TWS_ST_MR_DAT_ACK : `TWS_ST_MR_DAT_NACK;
                        end else begin
                           status_q <= ackRx_q ? `TWS_ST_MT_DAT_ACK : `TWS_ST_MT_DAT_NACK;
                        end
                     end else begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                     end
                  end
               end else if (startDet | stopDet) begin
                  sdaOe_q <= 1'b0;
                  if (slvAddr_q) begin
                     slvAddr_q <= 1'b0;
                     intFlag_q <= 1'b1;
                     status_q <= `TWS_ST_SR_STOP;
                     state_q <= ST_HOLD;
                  end else if (startDet) begin
                     phase_q <= 2'h1;
                     addrPhase_q <= 1'b1;
                     rx_q <= 1'b1;
                     bitCnt_q <= 4'h0;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end else begin
                  if (sclRise) begin
                     if (bitCnt_q[3]) begin
                        ackRx_q <= ~sdaF_q;
                     end else begin
                        data_q <= {data_q[6:0], sdaF_q};
                     end
                  end
                  if (sclFall & (phase_q == 2'h1)) begin
                     phase_q <= 2'h0;
                  end else if (sclFall) begin
                     if (bitCnt_q == 4'h7) begin
                        bitCnt_q <= 4'h8;
                        if (addrPhase_q) begin
                           if ((addrHit | gcHit) & ackEn_q) begin
                              sdaOe_q <= 1'b1;
                              gc_q <= gcHit & ~addrHit;
                           end else if (lost_q) begin
                              sdaOe_q <= 1'b0;
                              intFlag_q <= 1'b1;
                              status_q <= `TWS_ST_ARB_LOST;
                              state_q <= ST_HOLD;
                           end else begin
                              sdaOe_q <= 1'b0;
                              state_q <= ST_IDLE;
                           end
                        end else begin
                           sdaOe_q <= rx_q & ackEn_q;
                        end
                     end else if (bitCnt_q[3]) begin
                        bitCnt_q <= 4'h0;
                        sdaOe_q <= 1'b0;
                        sclOe_q <= 1'b1;
                        intFlag_q <= 1'b1;
                        state_q <= ST_HOLD;
                        if (addrPhase_q) begin
                           addrPhase_q <= 1'b0;
                           slvAddr_q <= 1'b1;
                           rx_q <= ~data_q[0];
                           lost_q <= 1'b0;
                           if (gc_q) begin
                              status_q <= `TWS_ST_SR_GC_ACK + (lost_q ? `TWS_ST_LOST_OFS : 8'h00);
                           end else if (data_q[0]) begin
                              status_q <= `TWS_ST_ST_SLA_ACK + (lost_q ? `TWS_ST_LOST_OFS : 8'h00);
                           end else begin
                              status_q <= `TWS_ST_SR_SLA_ACK + (lost_q ? `TWS_ST_LOST_OFS : 8'h00);
                           end
                        end else begin
                           if (~ackRx_q) begin
                              slvAddr_q <= 1'b0;
                           end
                           if (~rx_q) begin
                              status_q <= ackRx_q ? `TWS_ST_ST_DAT_ACK : `TWS_ST_ST_DAT_NACK;
                           end else if (gc_q) begin
                              status_q <= ackRx_q ? `TWS_ST_SR_GC_DAT_ACK : `TWS_ST_SR_GC_DAT_NACK;
                           end else begin
                              status_q <= ackRx_q ? `TWS_ST_SR_DAT_ACK : `TWS_ST_SR_DAT_NACK;
                           end
                        end
                     end else begin
                        bitCnt_q <= bitCnt_q + 4'h1;
                        sdaOe_q <= ~addrPhase_q & ~rx_q & ~data_q[7];
                     end
                  end
               end
            end
            ST_HOLD: begin
               if (~intFlag_q) begin
                  phase_q <= 2'h0;
                  bitCnt_q <= 4'h0;
                  if (stopReq_q & master_q) begin
                     state_q <= ST_STOP;
                  end else if (stopReq_q) begin
                     stopReq_q <= 1'b0;
                     slvAddr_q <= 1'b0;
                     sclOe_q <= 1'b0;
                     sdaOe_q <= 1'b0;
                     state_q <= ST_IDLE;
                  end else if (startReq_q & master_q) begin
                     state_q <= ST_START;
                  end else if (master_q | slvAddr_q) begin
                     state_q <= ST_BIT;
                     if (~master_q) begin
                        sclOe_q <= 1'b0;
                        sdaOe_q <= ~rx_q & ~data_q[7];
                     end
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_STOP: begin
               if (phase_q == 2'h0) begin
                  sdaOe_q <= 1'b1;
                  if (tick) begin
                     phase_q <= 2'h1;
                  end
               end else if (phase_q == 2'h1) begin
                  if (tick) begin
                     sclOe_q <= 1'b0;
                     phase_q <= 2'h2;
                  end
               end else if (phase_q == 2'h2) begin
                  if (tick & sclF_q) begin
                     sdaOe_q <= 1'b0;
                     phase_q <= 2'h3;
                  end
               end else if (tick) begin
                  stopReq_q <= 1'b0;
                  master_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase

         // Controller switched off drops every transfer and releases the pins
         if (~ifaceEn_q) begin
            state_q <= ST_IDLE;
            master_q <= 1'b0;
            slvAddr_q <= 1'b0;
            busBusy_q <= 1'b0;
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
         end
      end
   end
endmodule

// >>> test/tws_chk.sv
// Port checker for the two-wire controller
`timescale 1ns/1ps
module tws_chk (
   input wire clk,
   input wire rst,
   input wire [7:0] regAddr,
   input wire [7:0] regRdData_q,
   input wire cpuIntEn,
   input wire irq_q,
   input wire sclIn,
   input wire sclOut_q,
   input wire sclOe_q,
   input wire sdaOut_q,
   input wire sdaOe_q
);
   // ----------------
   // Port properties
   // ----------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_open_drain: assert property (!sclOut_q && !sdaOut_q) else $error("line driven high");
   chk_reset_quiet: assert property ($past(rst) |-> regRdData_q == 8'h00 && !irq_q && !sclOe_q && !sdaOe_q)
      else $error("outputs busy after reset");
   chk_irq_gate: assert property (irq_q |-> $past(cpuIntEn)) else $error("irq without global enable");
   chk_irq_flag: assert property (irq_q && $past(regAddr) == 8'hbc |-> regRdData_q[7] && regRdData_q[0])
      else $error("irq without flag and enable");
   chk_mask_lsb: assert property ($past(regAddr) == 8'hbd |-> !regRdData_q[0]) else $error("mask bit0 set");
   chk_flag_stretch: assert property (irq_q [*3] |-> $past(sclOe_q)) else $error("clock not held");
   chk_start_hold: assert property ($rose(sdaOe_q) && sclIn && !sclOe_q |=> !sclOe_q [*3])
      else $error("start too short");
   chk_stop_idle: assert property ($fell(sdaOe_q) && sclIn && !sclOe_q |=> !sdaOe_q [*3])
      else $error("line taken after stop");
   cover property ($rose(irq_q));
   cover property ($rose(sdaOe_q) && sclIn);
   cover property ($fell(sdaOe_q) && sclIn);
endmodule
bind tws_ctrl tws_chk chk (.clk(clk), .rst(rst), .regAddr(regAddr), .regRdData_q(regRdData_q),
   .cpuIntEn(cpuIntEn), .irq_q(irq_q), .sclIn(sclIn), .sclOut_q(sclOut_q), .sclOe_q(sclOe_q),
   .sdaOut_q(sdaOut_q), .sdaOe_q(sdaOe_q));

// >>> test/tws_ctrl_test.sv
// Self-checking bench for the two-wire controller registers
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; $display("BAD %0t %h %h", $time, a, b); end end
module tws_ctrl_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic regWr = 1'b0;
   logic cpuIntEn = 1'b0;
   logic ack;
   logic [7:0] regAddr = 8'hb8;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] rd;
   logic [7:0] rstVal [7] = '{8'h00, 8'hf8, 8'hfe, 8'hff, 8'h00, 8'h00, 8'h00};
   logic [39:0] sv [5] = '{40'ha000_45a0_60, 40'ha006_45a6_60, 40'ha100_4500_70, 40'ha000_05a0_f8, 40'ha000_45a2_f8};
   wire [7:0] rdData;
   wire irq, sclOut, sclOe, sdaOut, sdaOe, scl, sda;
   int err_count = 0;
   int checks = 0;
   tws_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
      .regRdData_q(rdData), .cpuIntEn(cpuIntEn), .irq_q(irq), .sclIn(scl), .sclOut_q(sclOut), .sclOe_q(sclOe),
      .sdaIn(sda), .sdaOut_q(sdaOut), .sdaOe_q(sdaOe));
   tws_peer peer (.clk(clk), .devSclOe(sclOe), .devSdaOe(sdaOe), .scl(scl), .sda(sda));
   // ----------------
   // Access tasks
   // ----------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWr <= 1'b1;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rdReg(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      repeat (2) @(posedge clk);
      #1 rd = rdData;
   endtask
   task automatic test_done;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic waitCtrl(input int b, input logic v);
      for (int n = 0; n < 3000; n++) begin
         rdReg(8'hbc);
         if (rd[b] === v) return;
      end
      err_count++;
      $display("BAD %0t timeout", $time);
      test_done;
   endtask
   initial forever #2 clk = ~clk;
   // ----------------
   // Sequence
   // ----------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rdReg(8'hb8 + i[7:0]);
         `CHK(rd, rstVal[i])
      end
      for (int i = 3; i >= 0; i--) begin
         wr(8'hb9, i[7:0]);
         rdReg(8'hb9);
         `CHK(rd, 8'hf8 | i[7:0])
      end
      wr(8'hbd, 8'hff);
      rdReg(8'hbd);
      `CHK(rd, 8'hfe)
      wr(8'hbd, 8'h00);
      ce <= 1'b0;
      wr(8'hbd, 8'h10);
      ce <= 1'b1;
      rdReg(8'hbd);
      `CHK(rd, 8'h00)
      cpuIntEn <= 1'b1;
      wr(8'hbb, 8'h33);
      rdReg(8'hbc);
      `CHK(rd[3], 1'b1)
      rdReg(8'hbb);
      `CHK(rd, 8'hff)
      wr(8'hbc, 8'ha5);
      waitCtrl(7, 1'b1);
      rdReg(8'hb9);
      `CHK(rd, 8'h08)
      `CHK({irq, sclOe}, 2'b11)
      wr(8'hbc, 8'h25);
      rdReg(8'hbc);
      `CHK(rd[7], 1'b1)
      wr(8'hbb, 8'h5a);
      rdReg(8'hbc);
      `CHK(rd[3], 1'b0)
      rdReg(8'hbb);
      `CHK(rd, 8'h5a)
      @(posedge clk);
      cpuIntEn <= 1'b0;
      repeat (3) @(posedge clk);
      #1 `CHK(irq, 1'b0)
      wr(8'hbc, 8'h85);
      waitCtrl(7, 1'b1);
      rdReg(8'hb9);
      `CHK(rd, 8'h20)
      rdReg(8'hbb);
      `CHK(rd, 8'h5a)
      wr(8'hbc, 8'h95);
      waitCtrl(4, 1'b0);
      `CHK(rd[7:4], 4'h0)
      for (int i = 0; i < 5; i++) begin
         wr(8'hba, sv[i][39:32]);
         wr(8'hbd, sv[i][31:24]);
         wr(8'hbc, sv[i][23:16]);
         peer.xfer(sv[i][15:8], ack);
         `CHK(ack, sv[i][7:0] != 8'hf8)
         if (sv[i][7:0] != 8'hf8) waitCtrl(7, 1'b1);
         rdReg(8'hb9);
         `CHK(rd, sv[i][7:0])
         if (sv[i][7:0] != 8'hf8) begin
            wr(8'hbc, 8'hd5);
            rdReg(8'hbc);
            `CHK(rd[4], 1'b0)
            `CHK({sclOe, sdaOe}, 2'b00)
         end
         peer.stop(ack);
         if (ack !== 1'b1) begin
            err_count++;
            $display("BAD %0t bus held", $time);
            test_done;
         end
      end
      wr(8'hbc, 8'ha5);
      waitCtrl(7, 1'b1);
      wr(8'hbc, 8'h01);
      repeat (2) @(posedge clk);
      #1 `CHK({sclOe, sdaOe}, 2'b00)
      test_done;
   end
endmodule

// >>> test/tws_peer.sv
// Model of another master on the two-wire bus
`timescale 1ns/1ps
module tws_peer #(parameter int H = 16) (
   input wire clk,
   input wire devSclOe,
   input wire devSdaOe,
   output wire scl,
   output wire sda
);
   // ----------------
   // Open-drain wires
   // ----------------
   logic pScl = 1'b0;
   logic pSda = 1'b0;
   assign scl = !(devSclOe || pScl);
   assign sda = !(devSdaOe || pSda);
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xfer(input logic [7:0] b, output logic ack);
      pSda <= 1'b1;
      hold(H);
      for (int i = 7; i >= 0; i--) begin
         pScl <= 1'b1;
         hold(H / 2);
         pSda <= !b[i];
         hold(H / 2);
         pScl <= 1'b0;
         hold(H);
      end
      pScl <= 1'b1;
      hold(H / 2);
      pSda <= 1'b0;
      hold(H / 2);
      pScl <= 1'b0;
      hold(H / 2);
      ack = !sda;
      hold(H / 2);
      pScl <= 1'b1;
   endtask
   task automatic stop(output logic ok);
      pSda <= 1'b1;
      hold(H);
      pScl <= 1'b0;
      for (int n = 0; n < 4000 && !scl; n++) hold(1);
      ok = scl;
      hold(H);
      pSda <= 1'b0;
      hold(H);
   endtask
endmodule
